/* File: hw/msc_cfg.svh */
// Constants for the motor stop-control block: setting codes, frequency scale, timing.
// Assumes frequencies arrive in 0.01 Hz units and settings as plain integers.
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH
`define MSC_STOP_DECEL_STD    16'd9999
`define MSC_STOP_DECEL_ALT    16'd8888
`define MSC_STOP_COAST_MAX    16'd100
`define MSC_STOP_ALT_BASE     16'd1000
`define MSC_STOP_ALT_MAX      16'd1100
`define MSC_THR_DISABLED      16'd9999
`define MSC_THR_MAX_HZ        16'd400
`define MSC_HZ_SCALE          32'd100
`define MSC_HYST_CENTI_HZ     32'd200
`define MSC_PM_START_CENTI    16'h0001
`define MSC_CLK_HZ            32'd10000000
`define MSC_TICK_NS           32'd100
`define MSC_BLINK_HALF_NS     32'd100000000
`define MSC_BLINK_HALF_CYC    (`MSC_BLINK_HALF_NS / `MSC_TICK_NS)
`endif

/* File: hw/msc_pkg.sv */
// Types for the motor stop-control block.
// Assumes the cfg header supplies all numeric constants.
package msc_pkg;
  typedef enum logic [3:0] {
    MSC_IDLE  = 4'b0001,
    MSC_RUN   = 4'b0010,
    MSC_DECEL = 4'b0100,
    MSC_COAST = 4'b1000
  } msc_state_e;
  typedef logic [15:0] msc_freq_t;
endpackage

/* File: hw/msc_timer.sv */
// Down-counting delay timer for the delayed-coast stop.
// Assumes one-cycle load pulses; counts down on every rising clock edge while armed.
`timescale 1ns/100ps
module msc_timer #(
  parameter int W = 32
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         load_i,
  input  wire logic         clear_i,
  input  wire logic [W-1:0] count_i,
  output logic              active_o,
  output logic              done_o
);
  logic [W-1:0] remain;
  logic         armed;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      remain <= '0;
      armed  <= 1'b0;
    end else if (clear_i) begin
      remain <= '0;
      armed  <= 1'b0;
    end else if (load_i) begin
      remain <= count_i;
      armed  <= 1'b1;
    end else if (armed && remain != '0) begin
      remain <= remain - 1'b1;
    end else begin
      armed  <= 1'b0;
    end
  end

  assign active_o = armed;
  assign done_o   = armed && (remain == '0);
endmodule

/* File: hw/msc_stop_ctrl.sv */
// Motor stop control: stop-method selection and low-frequency output stop.
// Assumes synchronous command inputs and frequencies in 0.01 Hz units.
// Operation
// - Settings 9999 or 8888 ramp the output down when start drops.
// - Settings 0 to 100 cut output that many seconds after start drops.
// - Settings 1000 to 1100 cut output after setting minus 1000 seconds.
// - 9999/0-100 use forward/reverse starts; 8888/1000-1100 use start plus direction.
// - Running indicator drops when delayed-coast stop cuts the output.
// - Stop setting ignored during power-fail, panel, comm-error or network stops.
// - Delayed-coast settings keep tracking the command until output shuts off.
// - Restart during coasting begins at the starting frequency.
// - Command and output at or below threshold cut the output to coast.
// - Threshold 9999 disables; enabled output stop suppresses DC injection braking.
// - Restart only above threshold plus 2 Hz, from starting or 0.01 Hz.
// - Compare the output frequency taken before slip compensation.
// - Output stop is disabled during process control, inching and power-fail stop.
// - No output stop during reverse deceleration unless both values reach threshold.
// - Blink direction lamps fast while held off with direction but no command.
// - Command falling to threshold with start held makes the drive coast.
`timescale 1ns/100ps
`include "msc_cfg.svh"
module msc_stop_ctrl #(
  parameter int unsigned CLK_HZ     = `MSC_CLK_HZ,
  parameter int unsigned BLINK_HALF = `MSC_BLINK_HALF_CYC
) (
  input  wire logic           core_clk_i,
  input  wire logic           rst_n_i,
  input  wire logic           forward_start_input_i,
  input  wire logic           reverse_start_input_i,
  input  wire logic [15:0]    stop_method_setting_i,
  input  wire logic [15:0]    coast_threshold_frequency_i,
  input  wire msc_pkg::msc_freq_t starting_frequency_setting_i,
  input  wire msc_pkg::msc_freq_t freq_command_i,
  input  wire msc_pkg::msc_freq_t output_freq_pre_slip_i,
  input  wire logic           output_freq_falling_i,
  input  wire logic           power_failure_stop_active_i,
  input  wire logic           panel_stop_active_i,
  input  wire logic           comm_error_stop_active_i,
  input  wire logic           network_estop_active_i,
  input  wire logic           process_control_active_i,
  input  wire logic           inching_active_i,
  input  wire logic           pm_motor_i,
  output logic                output_enable_o,
  output logic                run_cmd_o,
  output logic                reverse_dir_o,
  output logic                decel_to_stop_o,
  output logic                start_at_base_o,
  output msc_pkg::msc_freq_t  start_freq_o,
  output logic                dc_brake_inhibit_o,
  output logic                running_o,
  output logic                forward_lamp_o,
  output logic                reverse_lamp_o
);
  import msc_pkg::*;

  localparam logic [31:0] TICKS_PER_S = 32'(CLK_HZ);

  msc_state_e state;
  msc_state_e next_state;

  // Setting decode
  logic sel_decel_std;
  logic sel_decel_alt;
  logic sel_coast_std;
  logic sel_coast_alt;
  logic start_dir_mode;
  logic [15:0] delay_s;
  logic override_stop;

  always_comb begin
    sel_decel_std  = stop_method_setting_i == `MSC_STOP_DECEL_STD;
    sel_decel_alt  = stop_method_setting_i == `MSC_STOP_DECEL_ALT;
    sel_coast_std  = stop_method_setting_i <= `MSC_STOP_COAST_MAX;
    sel_coast_alt  = stop_method_setting_i >= `MSC_STOP_ALT_BASE &&
                     stop_method_setting_i <= `MSC_STOP_ALT_MAX;
    start_dir_mode = sel_decel_alt || sel_coast_alt;
    delay_s        = sel_coast_alt ? 16'(stop_method_setting_i - `MSC_STOP_ALT_BASE)
                                   : stop_method_setting_i;
    override_stop  = power_failure_stop_active_i || panel_stop_active_i ||
                     comm_error_stop_active_i || network_estop_active_i;
  end

  // Start and direction interpretation
  logic start_req;
  logic rev_req;
  always_comb begin
    if (start_dir_mode) begin
      start_req = forward_start_input_i;
      rev_req   = reverse_start_input_i;
    end else begin
      start_req = forward_start_input_i ^ reverse_start_input_i;
      rev_req   = reverse_start_input_i && !forward_start_input_i;
    end
  end

  logic start_q;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_req;
    end
  end
  wire start_fall = start_q && !start_req;

  // Delayed-coast timer, whole ticks per configured second
  logic        coast_sel;
  logic [31:0] delay_ticks;
  logic        tmr_active;
  logic        tmr_done;
  assign coast_sel   = (sel_coast_std || sel_coast_alt) && !override_stop;
  assign delay_ticks = 32'(delay_s) * TICKS_PER_S;

  msc_timer #(.W(32)) u_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (start_fall && coast_sel && state == MSC_RUN),
    .clear_i    (start_req || !coast_sel),
    .count_i    (delay_ticks),
    .active_o   (tmr_active),
    .done_o     (tmr_done)
  );

  // Low-frequency output stop
  logic        thr_enabled;
  logic [31:0] thr_centi;
  logic        cmd_low;
  logic        out_low;
  logic        cmd_restart;
  logic        lf_allowed;
  logic        lf_cut;
  logic        lf_hold;
  assign thr_enabled = coast_threshold_frequency_i != `MSC_THR_DISABLED &&
                       coast_threshold_frequency_i <= `MSC_THR_MAX_HZ;
  assign thr_centi   = 32'(coast_threshold_frequency_i) * `MSC_HZ_SCALE;
  assign cmd_low     = 32'(freq_command_i) <= thr_centi;
  assign out_low     = 32'(output_freq_pre_slip_i) <= thr_centi;
  assign cmd_restart = 32'(freq_command_i) > thr_centi + `MSC_HYST_CENTI_HZ;
  assign lf_allowed  = thr_enabled && !process_control_active_i &&
                       !inching_active_i && !power_failure_stop_active_i;
  // Reverse deceleration alone does not trigger; both values low does
  assign lf_cut      = lf_allowed && cmd_low && out_low &&
                       !(rev_req && output_freq_falling_i && !cmd_low);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      lf_hold <= 1'b0;
    end else if (!lf_allowed || !start_req) begin
      lf_hold <= 1'b0;
    end else if (lf_cut) begin
      lf_hold <= 1'b1;
    end else if (lf_hold && cmd_restart) begin
      lf_hold <= 1'b0;
    end
  end

  // Main sequencer
  always_comb begin
    next_state = state;
    case (state)
      MSC_IDLE: begin
        if (start_req && !lf_cut && (!lf_allowed || cmd_restart || !cmd_low)) begin
          next_state = MSC_RUN;
        end
      end
      MSC_RUN: begin
        if (lf_cut) begin
          next_state = MSC_COAST;
        end else if (!start_req) begin
          next_state = coast_sel ? MSC_RUN : MSC_DECEL;
        end
        if (tmr_done) begin
          next_state = MSC_COAST;
        end
      end
      MSC_DECEL: begin
        if (start_req) begin
          next_state = MSC_RUN;
        end else if (output_freq_pre_slip_i == '0) begin
          next_state = MSC_IDLE;
        end else if (lf_cut) begin
          next_state = MSC_COAST;
        end
      end
      MSC_COAST: begin
        if (start_req && !lf_hold && !lf_cut) begin
          next_state = MSC_RUN;
        end else if (!start_req) begin
          next_state = MSC_IDLE;
        end
      end
      default: next_state = MSC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state <= MSC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Restart frequency marker, pulse when leaving idle or coast
  logic restart_pulse;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      restart_pulse <= 1'b0;
      start_freq_o  <= '0;
    end else begin
      restart_pulse <= next_state == MSC_RUN && state != MSC_RUN && state != MSC_DECEL;
      start_freq_o  <= pm_motor_i && lf_allowed ? msc_freq_t'(`MSC_PM_START_CENTI)
                                                : starting_frequency_setting_i;
    end
  end
  assign start_at_base_o = restart_pulse;

  // Direction latch
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      reverse_dir_o <= 1'b0;
    end else if (start_req) begin
      reverse_dir_o <= rev_req;
    end
  end

  // Registered drive outputs
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      output_enable_o    <= 1'b0;
      run_cmd_o          <= 1'b0;
      decel_to_stop_o    <= 1'b0;
      running_o          <= 1'b0;
      dc_brake_inhibit_o <= 1'b0;
    end else begin
      output_enable_o    <= next_state == MSC_RUN || next_state == MSC_DECEL;
      run_cmd_o          <= next_state == MSC_RUN;
      decel_to_stop_o    <= next_state == MSC_DECEL;
      running_o          <= next_state == MSC_RUN || next_state == MSC_DECEL;
      dc_brake_inhibit_o <= thr_enabled;
    end
  end

  // Fast lamp blink while held off with direction but no frequency command
  logic [31:0] blink_cnt;
  logic        blink_ph;
  logic        lamp_blink;
  assign lamp_blink = state == MSC_COAST && start_req && cmd_low && lf_allowed;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      blink_cnt <= '0;
      blink_ph  <= 1'b0;
    end else if (!lamp_blink) begin
      blink_cnt <= '0;
      blink_ph  <= 1'b1;
    end else if (blink_cnt >= BLINK_HALF - 1) begin
      blink_cnt <= '0;
      blink_ph  <= !blink_ph;
    end else begin
      blink_cnt <= blink_cnt + 32'd1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      forward_lamp_o <= 1'b0;
      reverse_lamp_o <= 1'b0;
    end else begin
      forward_lamp_o <= start_req && !rev_req && (!lamp_blink || blink_ph);
      reverse_lamp_o <= start_req && rev_req && (!lamp_blink || blink_ph);
    end
  end

  // Assertions
  run_drop_coast_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == MSC_RUN && tmr_done |=> !running_o)
    else $error("run kept at coast");
  decel_sel_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == MSC_RUN && !start_req && !coast_sel && !lf_cut && !tmr_done
    |=> state == MSC_DECEL)
    else $error("no ramp stop");
  coast_cut_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == MSC_RUN && lf_cut |=> state == MSC_COAST && !output_enable_o)
    else $error("no low freq cut");
  hyst_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    lf_hold && !cmd_restart && start_req && lf_allowed |=> lf_hold)
    else $error("restart below hysteresis");
  lf_disable_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    inching_active_i || process_control_active_i |-> !lf_cut)
    else $error("output stop while disabled");
  override_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    override_stop |=> !tmr_active)
    else $error("coast timer under override");
  dc_inhibit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(thr_enabled) |=> dc_brake_inhibit_o)
    else $error("dc brake not inhibited");
  restart_base_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == MSC_COAST && next_state == MSC_RUN |=> start_at_base_o)
    else $error("no base restart");
  track_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == MSC_RUN && coast_sel && !tmr_done && !lf_cut |=> run_cmd_o)
    else $error("tracking dropped before shutoff");
  coast_load_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    start_fall && coast_sel && state == MSC_RUN |=> tmr_active)
    else $error("coast delay not started");
  alt_delay_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sel_coast_alt |-> delay_s + `MSC_STOP_ALT_BASE == stop_method_setting_i)
    else $error("offset delay wrong");
  both_starts_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == MSC_IDLE && !start_dir_mode && forward_start_input_i && reverse_start_input_i
    |=> !output_enable_o)
    else $error("both starts ran");
  dir_select_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    start_dir_mode && forward_start_input_i |=> reverse_dir_o == $past(reverse_start_input_i))
    else $error("direction input ignored");
  pm_restart_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == MSC_COAST && next_state == MSC_RUN && pm_motor_i && lf_allowed
    |=> start_freq_o == `MSC_PM_START_CENTI)
    else $error("pm restart not from minimum");
  pre_slip_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == MSC_RUN && !tmr_done &&
    32'(output_freq_pre_slip_i) > 32'(coast_threshold_frequency_i) * `MSC_HZ_SCALE
    |=> state != MSC_COAST)
    else $error("cut above threshold");
  rev_decel_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == MSC_RUN && rev_req && output_freq_falling_i && !cmd_low && !tmr_done
    |=> state != MSC_COAST)
    else $error("cut in reverse decel");
  blink_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    lamp_blink && !blink_ph |=> !forward_lamp_o && !reverse_lamp_o)
    else $error("lamp lit in dark phase");
  cmd_drop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == MSC_RUN && start_req && lf_cut |=> !output_enable_o && lf_hold)
    else $error("no coast on low command");
  ovr_ramp_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == MSC_RUN && override_stop && !start_req && !lf_cut && !tmr_done
    |=> state == MSC_DECEL)
    else $error("delay used under override");
  ramp_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state == MSC_DECEL && !start_req && output_freq_pre_slip_i != '0 && !lf_cut
    |=> decel_to_stop_o)
    else $error("ramp abandoned");
  pf_no_lf_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    power_failure_stop_active_i |-> !lf_cut)
    else $error("output stop in power fail");
  thr_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !thr_enabled |=> !lf_hold)
    else $error("hold kept while disabled");

  coast_seen_c:  cover property (@(posedge core_clk_i) state == MSC_RUN ##1 state == MSC_COAST);
  decel_seen_c:  cover property (@(posedge core_clk_i) state == MSC_DECEL ##1 state == MSC_IDLE);
  restart_c:     cover property (@(posedge core_clk_i) state == MSC_COAST ##1 state == MSC_RUN);
  blink_c:       cover property (@(posedge core_clk_i) lamp_blink && $changed(blink_ph));
  std_ramp_c:    cover property (@(posedge core_clk_i) sel_decel_std && state == MSC_DECEL);
endmodule

/* File: tb/msc_drive_model.sv */
// Far-side model: power stage that ramps its output frequency after the block's commands.
// Assumes 0.01 Hz units and a ramp step of 1 Hz per clock.
`timescale 1ns/100ps
module msc_drive_model (
  input  wire logic               core_clk_i,
  input  wire logic               enable_i,
  input  wire logic               track_i,
  input  wire logic               ramp_stop_i,
  input  wire logic               load_base_i,
  input  wire msc_pkg::msc_freq_t base_i,
  input  wire msc_pkg::msc_freq_t cmd_i,
  output msc_pkg::msc_freq_t      freq_o,
  output logic                    falling_o
);
  import msc_pkg::*;
  // Stage off or not yet driven reports zero; value is the one before slip compensation
  always @(posedge core_clk_i) begin
    if (enable_i !== 1'b1)
      freq_o <= '0;
    else if (load_base_i)
      freq_o <= base_i;
    else if (ramp_stop_i)
      freq_o <= (freq_o > 16'h0064) ? freq_o - 16'h0064 : '0;
    else if (track_i && freq_o < cmd_i)
      freq_o <= (cmd_i - freq_o > 16'h0064) ? freq_o + 16'h0064 : cmd_i;
    else if (track_i && freq_o > cmd_i)
      freq_o <= (freq_o - cmd_i > 16'h0064) ? freq_o - 16'h0064 : cmd_i;
  end
  assign falling_o = ramp_stop_i || (freq_o > cmd_i);
endmodule

/* File: tb/motor_stop_control_tb.sv */
// Self-checking bench for the motor stop-control block.
// Assumes the drive model closes the frequency loop; delays scaled by CLK_HZ.
`timescale 1ns/100ps
module motor_stop_control_tb;
  import msc_pkg::*;
  localparam int CLKHZ = 10;
  localparam logic [15:0] SET_STD = 16'h270f;
  localparam logic [15:0] SET_ALT = 16'h22b8;
  localparam logic [15:0] THR5    = 16'h0005;
  logic        clk = 0, rst_n = 0, fwd = 0, rev = 0, pf = 0, panel = 0, comm = 0, net = 0;
  logic        pid = 0, inch = 0, pm = 0, falling;
  logic [15:0] stop_set = SET_STD, thr = SET_STD;
  msc_freq_t   start_set = 16'h0064, cmd = '0, ofreq, sfreq, cap;
  logic        oe, run, rdir, dec, sab, dcb, running, fl, rl, s;
  int          err_count = 0, n_compared = 0, cycles = 0, n, tog;
  logic [31:0] seed = 32'h00013830;
  logic [15:0] coast_set [2] = '{16'h0003, 16'h03ea};
  msc_freq_t   exp_q[$];

  always #50 clk = ~clk;

  msc_stop_ctrl #(.CLK_HZ(CLKHZ), .BLINK_HALF(4)) uut (
    .core_clk_i(clk), .rst_n_i(rst_n), .forward_start_input_i(fwd),
    .reverse_start_input_i(rev), .stop_method_setting_i(stop_set),
    .coast_threshold_frequency_i(thr), .starting_frequency_setting_i(start_set),
    .freq_command_i(cmd), .output_freq_pre_slip_i(ofreq), .output_freq_falling_i(falling),
    .power_failure_stop_active_i(pf), .panel_stop_active_i(panel),
    .comm_error_stop_active_i(comm), .network_estop_active_i(net),
    .process_control_active_i(pid), .inching_active_i(inch), .pm_motor_i(pm),
    .output_enable_o(oe), .run_cmd_o(run), .reverse_dir_o(rdir), .decel_to_stop_o(dec),
    .start_at_base_o(sab), .start_freq_o(sfreq), .dc_brake_inhibit_o(dcb),
    .running_o(running), .forward_lamp_o(fl), .reverse_lamp_o(rl));

  msc_drive_model drv (
    .core_clk_i(clk), .enable_i(oe), .track_i(run), .ramp_stop_i(dec), .load_base_i(sab),
    .base_i(sfreq), .cmd_i(cmd), .freq_o(ofreq), .falling_o(falling));

  function automatic logic [15:0] rnd(input logic [15:0] lo, input logic [15:0] span);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return lo + 16'(seed % span);
  endfunction

  // Expected shut-off delay in ticks for a delayed-coast setting
  function automatic int dly(input int st);
    return (st >= 1000 ? st - 1000 : st) * CLKHZ;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Inputs change on falling edges and hold at least one tick
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  task automatic wait_oe(input logic lvl, input int lim);
    n = 0;
    while (oe !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic seen_base();
    s = 0;
    repeat (4) begin
      @(negedge clk);
      if (sab === 1'b1) begin
        s = 1;
        cap = sfreq;
      end
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    cyc(10);
    chk(oe, 0, "oe in reset");
    chk(running, 0, "running in reset");
    rst_n = 1;
    cyc(2);
    cmd = rnd(16'h03e8, 16'h07d0);
    start_set = rnd(16'h0032, 16'h00c8);
    fwd = 1;
    cyc(30);
    chk(running, 1, "running");
    chk(rdir, 0, "fwd dir");
    fwd = 0;
    cyc(2);
    chk(dec, 1, "ramp stop");
    chk(oe, 1, "still driven");
    wait_oe(0, 60);
    chk(oe, 0, "ramp end");
    rev = 1;
    cyc(5);
    chk(rdir, 1, "rev start");
    rev = 0;
    wait_oe(0, 60);
    stop_set = SET_ALT;
    fwd = 1;
    rev = 1;
    cyc(5);
    chk(rdir, 1, "alt reverse");
    rev = 0;
    cyc(3);
    chk(rdir, 0, "alt forward");
    fwd = 0;
    wait_oe(0, 60);
    rev = 1;
    cyc(5);
    chk(oe, 0, "direction only");
    rev = 0;
    $display("test start_modes done");
    foreach (coast_set[i]) begin
      stop_set = coast_set[i];
      fwd = 1;
      cyc(20);
      fwd = 0;
      cyc(dly(coast_set[i]) - 8);
      chk(oe, 1, "coast pending");
      chk(dec, 0, "no ramp");
      wait_oe(0, 20);
      n = n + dly(coast_set[i]) - 8;
      chk(16'(n >= dly(coast_set[i]) && n <= dly(coast_set[i]) + 4), 1, "delay");
      chk(running, 0, "run flag off");
      fwd = 1;
      exp_q.push_back(start_set);
      seen_base();
      chk(s, 1, "restart pulse");
      chk(cap, exp_q.pop_front(), "restart freq");
      fwd = 0;
      wait_oe(0, 60);
    end
    panel = 1;
    fwd = 1;
    cyc(20);
    fwd = 0;
    cyc(2);
    chk(dec, 1, "override ramps");
    panel = 0;
    wait_oe(0, 60);
    chk(oe, 0, "override stop end");
    $display("test delayed_coast done");
    stop_set = SET_STD;
    thr = THR5;
    fwd = 1;
    cyc(30);
    chk(dcb, 1, "dc inhibit");
    cmd = 16'h012c;
    wait_oe(0, 30);
    chk(oe, 0, "low freq cut");
    tog = 0;
    repeat (12) begin
      s = fl;
      cyc(1);
      tog += (fl !== s);
    end
    chk(16'(tog > 0), 1, "lamp blink");
    cmd = 16'h02bc;
    cyc(10);
    chk(oe, 16'(int'(cmd) > int'(thr) * 100 + 200), "hysteresis hold");
    pm = 1;
    cmd = 16'h02bd;
    exp_q.push_back(16'h0001);
    seen_base();
    chk(s, 1, "restart above");
    chk(cap, exp_q.pop_front(), "pm start");
    pm = 0;
    fwd = 0;
    wait_oe(0, 60);
    $display("test output_stop done");
    thr = SET_STD;
    cmd = rnd(16'h03e8, 16'h07d0);
    fwd = 1;
    cyc(30);
    chk(dcb, 0, "inhibit off");
    cmd = 16'h012c;
    cyc(20);
    chk(oe, 1, "stop disabled");
    thr = THR5;
    inch = 1;
    cyc(20);
    chk(oe, 1, "inching");
    inch = 0;
    pid = 1;
    cyc(20);
    chk(oe, 1, "process control");
    pid = 0;
    fwd = 0;
    wait_oe(0, 60);
    $display("test stop_disable done");
    final_report();
  end
endmodule
